// ===== cap_seq_pkg.sv
package cap_seq_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_BANK0 = 8'h04;
    localparam logic [7:0] OFS_BANK1 = 8'h08;
    localparam logic [7:0] OFS_INTERVAL0 = 8'h0c;
    localparam logic [7:0] OFS_INTERVAL1 = 8'h10;
    localparam logic [7:0] OFS_COMMAND = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [23:0] CTRL_RST = 24'h00_0800;
    localparam logic [17:0] BANK_RST = 18'h0_0000;
    localparam logic [23:0] INTERVAL_RST = 24'h00_0000;

    ////////////////////////////////////////////////////////////////////////
    // Control register fields
    localparam int CTRL_W = 24;
    localparam int F_PORT_EN = 0;
    localparam int F_REF_INT = 8;
    localparam int F_DIFF = 9;
    localparam int F_FLOAT = 10;
    localparam int F_COMP_INT = 11;
    localparam int F_COMP_EXT = 12;
    localparam int F_COMP_R = 13;
    localparam int F_BAL = 14;
    localparam int F_FORCE = 15;
    localparam int F_FAKE = 16;
    localparam int F_PIN_SEL = 20;
    localparam int F_RETRIG = 22;
    localparam int F_BANK = 23;

    // Bank register fields
    localparam int BANK_W = 18;
    localparam int F_AVG = 0;
    localparam int AVG_W = 13;
    localparam int F_TRIG = 16;

    // Status register fields
    localparam int F_ST_BUSY = 0;
    localparam int F_ST_BANK = 1;
    localparam int F_ST_COUNT = 16;

    ////////////////////////////////////////////////////////////////////////
    // Trigger selector codes
    localparam logic [1:0] TRIG_OFF_STRETCH = 2'h0;
    localparam logic [1:0] TRIG_SINGLE_CONT = 2'h1;
    localparam logic [1:0] TRIG_TIMER = 2'h2;
    localparam logic [1:0] TRIG_PIN = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // Sequence slots, in order of execution
    localparam logic [4:0] SLOT_REF = 5'h00;
    localparam logic [4:0] SLOT_PORT0 = 5'h01;
    localparam logic [4:0] SLOT_CINT = 5'h09;
    localparam logic [4:0] SLOT_CEXT = 5'h0a;
    localparam logic [4:0] SLOT_CR = 5'h0b;
    localparam logic [4:0] SLOT_BAL0 = 5'h0c;
    localparam logic [4:0] SLOT_LAST = 5'h13;

    localparam logic [3:0] REF_PORT_EXT = 4'h0;
    localparam logic [3:0] REF_PORT_INT = 4'h8;

    // Low-frequency periods per conversion-time unit
    localparam int LF_PER_UNIT = 2;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [2:0] {
        KIND_REF,
        KIND_PORT,
        KIND_COMP_INT,
        KIND_COMP_EXT,
        KIND_COMP_R,
        KIND_BALANCE
    } meas_kind_e;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ISSUE,
        ST_WAIT,
        ST_NEXT
    } seq_state_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        meas_kind_e kind;
        logic [3:0] port;
        logic floating;
        logic differential;
        logic inactive_dummy;
        logic discard;
    } meas_cmd_s;

endpackage

// ===== cap_seq.sv
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module cap_seq
    import cap_seq_pkg::*;
#(
    parameter int INTERVAL_W = 24,
    parameter int NUM_PINS = 4
) (
    input wire logic clock_i,                    // 20 MHz clock
    input wire logic rst_i,                      // Async reset, high
    input wire apb_req_s apb_i,                  // APB request
    output logic apb_pready_o,                   // APB ready
    output logic apb_pslverr_o,                  // APB error
    output logic [31:0] apb_prdata_o,            // APB read data
    input wire logic low_frequency_oscillator_i, // LF clock pin
    input wire logic [NUM_PINS-1:0] gpio_i,      // Trigger pins
    input wire logic dsp_start_i,                // Processor start pulse
    input wire logic processor_end_i,            // Processor end pulse
    input wire logic meas_done_i,                // Front end done pulse
    output logic meas_start_o,                   // Measurement start
    output meas_cmd_s meas_cmd_o,                // Measurement setup
    output logic busy_o,                         // Conversion running
    output logic eoc_o                           // End of conversion
);

    ////////////////////////////////////////////////////////////////////////
    // APB register file
    logic [CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [BANK_W-1:0] bank0_q, bank0_d, bank1_q, bank1_d;
    logic [INTERVAL_W-1:0] int0_q, int0_d, int1_q, int1_d;
    logic [31:0] prdata_q, prdata_d;
    logic cmd_start_q, cmd_start_d;
    logic [15:0] conv_count_q;
    logic sh_bank_q;
    seq_state_e state_q;
    logic access, wr_en, mapped;
    logic [7:0] ofs;

    assign ofs = apb_i.paddr[7:0];
    assign access = apb_i.psel && apb_i.penable;
    assign wr_en = access && apb_i.pwrite;

    always_comb begin
        mapped = (apb_i.paddr[31:8] == 24'h00_0000) && (ofs[1:0] == 2'h0)
            && (ofs <= OFS_STATUS);
        ctrl_d = ctrl_q;
        bank0_d = bank0_q;
        bank1_d = bank1_q;
        int0_d = int0_q;
        int1_d = int1_q;
        cmd_start_d = 1'b0;
        prdata_d = prdata_q;
        if (wr_en && mapped) begin
            unique case (ofs)
                OFS_CTRL: ctrl_d = apb_i.pwdata[CTRL_W-1:0];
                OFS_BANK0: bank0_d = apb_i.pwdata[BANK_W-1:0];
                OFS_BANK1: bank1_d = apb_i.pwdata[BANK_W-1:0];
                OFS_INTERVAL0: int0_d = apb_i.pwdata[INTERVAL_W-1:0];
                OFS_INTERVAL1: int1_d = apb_i.pwdata[INTERVAL_W-1:0];
                OFS_COMMAND: cmd_start_d = apb_i.pwdata[0];
                default: cmd_start_d = 1'b0;
            endcase
        end
        if (apb_i.psel && !apb_i.penable) begin
            prdata_d = 32'h0000_0000;
            unique case (ofs)
                OFS_CTRL: prdata_d[CTRL_W-1:0] = ctrl_q;
                OFS_BANK0: prdata_d[BANK_W-1:0] = bank0_q;
                OFS_BANK1: prdata_d[BANK_W-1:0] = bank1_q;
                OFS_INTERVAL0: prdata_d[INTERVAL_W-1:0] = int0_q;
                OFS_INTERVAL1: prdata_d[INTERVAL_W-1:0] = int1_q;
                OFS_STATUS: begin
                    prdata_d[F_ST_BUSY] = (state_q != ST_IDLE);
                    prdata_d[F_ST_BANK] = sh_bank_q;
                    prdata_d[F_ST_COUNT +: 16] = conv_count_q;
                end
                default: prdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_q <= CTRL_RST;
            bank0_q <= BANK_RST;
            bank1_q <= BANK_RST;
            int0_q <= INTERVAL_RST[INTERVAL_W-1:0];
            int1_q <= INTERVAL_RST[INTERVAL_W-1:0];
            cmd_start_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            ctrl_q <= ctrl_d;
            bank0_q <= bank0_d;
            bank1_q <= bank1_d;
            int0_q <= int0_d;
            int1_q <= int1_d;
            cmd_start_q <= cmd_start_d;
            prdata_q <= prdata_d;
        end
    end

    assign apb_pready_o = 1'b1;
    assign apb_pslverr_o = access && !mapped;
    assign apb_prdata_o = prdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detect
    logic [NUM_PINS:0] sync1_q, sync2_q, sync3_q, lvl_q, lvl_d;
    logic [NUM_PINS:0] pins_in;
    logic lf_edge, pin_edge;

    assign pins_in = {low_frequency_oscillator_i, gpio_i};

    always_comb begin
        lvl_d = lvl_q;
        for (int i = 0; i <= NUM_PINS; i++) begin
            if (sync2_q[i] == sync3_q[i]) begin
                lvl_d[i] = sync3_q[i];
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
            lvl_q <= '0;
        end else begin
            sync1_q <= pins_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            lvl_q <= lvl_d;
        end
    end

    assign lf_edge = lvl_d[NUM_PINS] && !lvl_q[NUM_PINS];
    assign pin_edge = lvl_d[ctrl_q[F_PIN_SEL +: 2]]
        && !lvl_q[ctrl_q[F_PIN_SEL +: 2]];

    ////////////////////////////////////////////////////////////////////////
    // Active bank, mode decode, conversion timer
    logic [1:0] act_trig;
    logic [AVG_W-1:0] act_avg;
    logic [INTERVAL_W-1:0] act_int;
    logic time_zero, mode_off, mode_stretch, mode_cont, mode_single;
    logic mode_timer, mode_pin, take;
    logic [INTERVAL_W:0] tmr_q, tmr_d, target;
    logic tmr_exp;
    logic pending_q, pending_d;

    assign act_trig = ctrl_q[F_BANK] ? bank1_q[F_TRIG +: 2]
        : bank0_q[F_TRIG +: 2];
    assign act_avg = ctrl_q[F_BANK] ? bank1_q[F_AVG +: AVG_W]
        : bank0_q[F_AVG +: AVG_W];
    assign act_int = ctrl_q[F_BANK] ? int1_q : int0_q;
    assign time_zero = (act_int == '0);
    assign mode_off = (act_trig == TRIG_OFF_STRETCH) && time_zero;
    assign mode_stretch = (act_trig == TRIG_OFF_STRETCH) && !time_zero;
    assign mode_cont = (act_trig == TRIG_SINGLE_CONT) && !time_zero;
    assign mode_single = (act_trig == TRIG_SINGLE_CONT) && time_zero;
    assign mode_timer = (act_trig == TRIG_TIMER);
    assign mode_pin = (act_trig == TRIG_PIN);
    assign target = (INTERVAL_W+1)'(LF_PER_UNIT) * {1'b0, act_int};

    always_comb begin
        tmr_d = tmr_q;
        tmr_exp = 1'b0;
        if (!(mode_stretch || mode_timer) || time_zero) begin
            tmr_d = '0;
        end else if (mode_stretch && take) begin
            tmr_d = '0;
        end else if (lf_edge) begin
            if (tmr_q + 1'b1 >= target) begin
                tmr_exp = 1'b1;
                tmr_d = '0;
            end else begin
                tmr_d = tmr_q + 1'b1;
            end
        end
    end

    always_comb begin
        pending_d = pending_q && !take;
        if ((mode_single || mode_pin) && (cmd_start_q || dsp_start_i)) begin
            pending_d = 1'b1;
        end
        if (mode_pin && pin_edge) begin
            pending_d = 1'b1;
        end
        if ((mode_stretch || mode_timer) && tmr_exp) begin
            pending_d = 1'b1;
        end
        if (ctrl_q[F_RETRIG] && processor_end_i) begin
            pending_d = 1'b1;
        end
        if (mode_off) begin
            pending_d = 1'b0;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            tmr_q <= '0;
            pending_q <= 1'b0;
        end else begin
            tmr_q <= tmr_d;
            pending_q <= pending_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Measurement sequencer
    function automatic logic port_on(input logic [2:0] i,
                                     input logic [CTRL_W-1:0] c);
        logic ext_ref;
        ext_ref = !c[F_REF_INT] || c[F_DIFF];
        return c[F_PORT_EN + int'(i)]
            && !(ext_ref && i == 3'h0)
            && !(c[F_DIFF] && i[0]);
    endfunction

    function automatic logic slot_on(input logic [4:0] s,
                                     input logic [CTRL_W-1:0] c);
        logic on;
        on = 1'b0;
        if (s == SLOT_REF) begin
            on = 1'b1;
        end else if (s < SLOT_CINT) begin
            on = port_on(3'(s - SLOT_PORT0), c);
        end else if (s == SLOT_CINT) begin
            on = c[F_COMP_INT];
        end else if (s == SLOT_CEXT) begin
            on = c[F_COMP_EXT] && c[F_FLOAT];
        end else if (s == SLOT_CR) begin
            on = c[F_COMP_R];
        end else if (s <= SLOT_LAST) begin
            on = c[F_BAL] && (c[F_DIFF] || c[F_FLOAT])
                && port_on(3'(s - SLOT_BAL0), c);
        end
        return on;
    endfunction

    seq_state_e state_d;
    logic [4:0] slot_q, slot_d;
    logic [13:0] seq_cnt_q, seq_cnt_d, total;
    logic [CTRL_W-1:0] sh_ctrl_q, sh_ctrl_d;
    logic [AVG_W-1:0] sh_avg_q, sh_avg_d;
    logic sh_bank_d;
    logic [15:0] conv_count_d;
    logic eoc_q, eoc_d, start_q, start_d;
    meas_cmd_s cmd_q, cmd_d;
    logic [3:0] fake;

    assign fake = sh_ctrl_q[F_FAKE +: 4];
    assign total = 14'(fake) + ((sh_avg_q == '0) ? 14'h0001
        : 14'(sh_avg_q));
    assign take = (state_q == ST_IDLE) && !mode_off
        && (mode_cont || pending_q);

    always_comb begin
        state_d = state_q;
        slot_d = slot_q;
        seq_cnt_d = seq_cnt_q;
        sh_ctrl_d = sh_ctrl_q;
        sh_avg_d = sh_avg_q;
        sh_bank_d = sh_bank_q;
        conv_count_d = conv_count_q;
        eoc_d = 1'b0;
        start_d = 1'b0;
        cmd_d = cmd_q;
        unique case (state_q)
            ST_IDLE: begin
                if (take) begin
                    sh_ctrl_d = ctrl_q;
                    sh_avg_d = act_avg;
                    sh_bank_d = ctrl_q[F_BANK];
                    slot_d = SLOT_REF;
                    seq_cnt_d = '0;
                    state_d = ST_ISSUE;
                end
            end
            ST_ISSUE: begin
                if (slot_on(slot_q, sh_ctrl_q)) begin
                    start_d = 1'b1;
                    cmd_d.port = 4'h0;
                    if (slot_q == SLOT_REF) begin
                        cmd_d.kind = KIND_REF;
                        cmd_d.port = (sh_ctrl_q[F_REF_INT] && !sh_ctrl_q[F_DIFF])
                            ? REF_PORT_INT : REF_PORT_EXT;
                    end else if (slot_q < SLOT_CINT) begin
                        cmd_d.kind = KIND_PORT;
                        cmd_d.port = 4'(slot_q - SLOT_PORT0);
                    end else if (slot_q == SLOT_CINT) begin
                        cmd_d.kind = KIND_COMP_INT;
                    end else if (slot_q == SLOT_CEXT) begin
                        cmd_d.kind = KIND_COMP_EXT;
                    end else if (slot_q == SLOT_CR) begin
                        cmd_d.kind = KIND_COMP_R;
                    end else begin
                        cmd_d.kind = KIND_BALANCE;
                        cmd_d.port = 4'(slot_q - SLOT_BAL0);
                    end
                    cmd_d.floating = sh_ctrl_q[F_FLOAT];
                    cmd_d.differential = sh_ctrl_q[F_DIFF];
                    cmd_d.inactive_dummy = sh_ctrl_q[F_DIFF]
                        && sh_ctrl_q[F_FORCE];
                    cmd_d.discard = (seq_cnt_q < 14'(fake));
                    state_d = ST_WAIT;
                end else if (slot_q == SLOT_LAST) begin
                    state_d = ST_NEXT;
                end else begin
                    slot_d = slot_q + 5'h01;
                end
            end
            ST_WAIT: begin
                if (meas_done_i) begin
                    if (slot_q == SLOT_LAST) begin
                        state_d = ST_NEXT;
                    end else begin
                        slot_d = slot_q + 5'h01;
                        state_d = ST_ISSUE;
                    end
                end
            end
            ST_NEXT: begin
                if (seq_cnt_q + 14'h0001 >= total) begin
                    eoc_d = 1'b1;
                    conv_count_d = conv_count_q + 16'h0001;
                    state_d = ST_IDLE;
                end else begin
                    seq_cnt_d = seq_cnt_q + 14'h0001;
                    slot_d = SLOT_REF;
                    state_d = ST_ISSUE;
                end
            end
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            slot_q <= SLOT_REF;
            seq_cnt_q <= '0;
            sh_ctrl_q <= CTRL_RST;
            sh_avg_q <= '0;
            sh_bank_q <= 1'b0;
            conv_count_q <= 16'h0000;
            eoc_q <= 1'b0;
            start_q <= 1'b0;
            cmd_q <= '0;
        end else begin
            state_q <= state_d;
            slot_q <= slot_d;
            seq_cnt_q <= seq_cnt_d;
            sh_ctrl_q <= sh_ctrl_d;
            sh_avg_q <= sh_avg_d;
            sh_bank_q <= sh_bank_d;
            conv_count_q <= conv_count_d;
            eoc_q <= eoc_d;
            start_q <= start_d;
            cmd_q <= cmd_d;
        end
    end

    assign meas_start_o = start_q;
    assign meas_cmd_o = cmd_q;
    assign eoc_o = eoc_q;
    assign busy_o = (state_q != ST_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    sequence s_last_seq;
        state_q == ST_NEXT && seq_cnt_q + 14'h0001 >= total;
    endsequence

    sequence s_port_start;
        meas_start_o && meas_cmd_o.kind == KIND_PORT;
    endsequence

    AST_PORT_ENABLED: assert property (s_port_start
        |-> sh_ctrl_q[F_PORT_EN + int'(meas_cmd_o.port[2:0])])
        else $error("disabled port measured");
    AST_REF_PORT: assert property (meas_start_o
        && meas_cmd_o.kind == KIND_REF |-> meas_cmd_o.port ==
        ((sh_ctrl_q[F_REF_INT] && !sh_ctrl_q[F_DIFF]) ? REF_PORT_INT
        : REF_PORT_EXT))
        else $error("wrong reference port");
    AST_DIFF_PAIR: assert property ((s_port_start
        and sh_ctrl_q[F_DIFF]) |-> !meas_cmd_o.port[0])
        else $error("odd port in differential mode");
    AST_COMP_INT: assert property (meas_start_o
        && meas_cmd_o.kind == KIND_COMP_INT |-> sh_ctrl_q[F_COMP_INT])
        else $error("internal compensation not enabled");
    AST_COMP_EXT: assert property (meas_start_o
        && meas_cmd_o.kind == KIND_COMP_EXT
        |-> sh_ctrl_q[F_COMP_EXT] && sh_ctrl_q[F_FLOAT])
        else $error("external compensation without floating");
    AST_COMP_R: assert property (meas_start_o
        && meas_cmd_o.kind == KIND_COMP_R |-> sh_ctrl_q[F_COMP_R])
        else $error("resistance compensation not enabled");
    AST_BALANCE: assert property (meas_start_o
        && meas_cmd_o.kind == KIND_BALANCE |-> sh_ctrl_q[F_BAL]
        && (sh_ctrl_q[F_DIFF] || sh_ctrl_q[F_FLOAT]))
        else $error("balance in single grounded mode");
    AST_DUMMY: assert property (meas_start_o
        |-> meas_cmd_o.inactive_dummy == (sh_ctrl_q[F_DIFF]
        && sh_ctrl_q[F_FORCE]))
        else $error("inactive electrode control wrong");
    AST_DISCARD: assert property (meas_start_o
        |-> meas_cmd_o.discard == (seq_cnt_q < 14'(fake)))
        else $error("discard flag wrong");
    AST_CONT: assert property (eoc_o && mode_cont
        |=> state_q == ST_ISSUE)
        else $error("continuous mode did not restart");
    AST_OFF: assert property (state_q == ST_IDLE && mode_off
        |=> state_q == ST_IDLE)
        else $error("conversion started in off mode");
    AST_EOC: assert property (s_last_seq |=> eoc_o
        && state_q == ST_IDLE)
        else $error("missing end of conversion");
    AST_EOC_CAUSE: assert property (eoc_o |-> $past(state_q) == ST_NEXT)
        else $error("stray end of conversion");
    AST_SHADOW: assert property (state_q != ST_IDLE
        && $past(state_q) != ST_IDLE |-> $stable(sh_ctrl_q)
        && $stable(sh_avg_q))
        else $error("configuration changed mid conversion");
    AST_TIMER: assert property (tmr_exp
        |-> tmr_q + 1'b1 >= target && lf_edge)
        else $error("timer expired early");

endmodule

// ===== cap_front_end.sv
`timescale 1ns/1ps
module cap_front_end (
    input wire logic clock_i,      // Clock
    input wire logic rst_i,        // Async reset, high
    input wire logic [3:0] lat_i,  // Answer delay in cycles
    input wire logic meas_start_i, // Measurement launch
    output logic meas_done_o       // Measurement finished pulse
);
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    always_comb begin
        cnt_d = cnt_q;
        if (meas_start_i) begin
            cnt_d = {1'b0, lat_i} + 5'h1;
        end else if (cnt_q != 5'h0) begin
            cnt_d = cnt_q - 5'h1;
        end
    end
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= 5'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
    // Single pulse as the delay runs out
    assign meas_done_o = (cnt_q == 5'h1);
endmodule

// ===== tb_cap_seq.sv
`timescale 1ns/1ps
module tb_cap_seq;
    import cap_seq_pkg::*;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    apb_req_s apb_q = '0;
    logic pready, pslverr, mstart, mdone, busy, eoc, lf = 1'b0;
    logic pend = 1'b0, dstart = 1'b0;
    logic [3:0] gpio = 4'h0, lat = 4'h2;
    logic [31:0] prdata, rd_v;
    logic err_v;
    meas_cmd_s cmd;
    meas_cmd_s firsts [0:2];
    int fails = 0, samples_checked = 0, cycles = 0;
    int starts = 0, discards = 0, eocs = 0;
    cap_seq u_cap_seq (.clock_i(clock_i), .rst_i(rst_i), .apb_i(apb_q),
        .apb_pready_o(pready), .apb_pslverr_o(pslverr),
        .apb_prdata_o(prdata), .low_frequency_oscillator_i(lf),
        .gpio_i(gpio), .dsp_start_i(dstart), .processor_end_i(pend),
        .meas_done_i(mdone), .meas_start_o(mstart), .meas_cmd_o(cmd),
        .busy_o(busy), .eoc_o(eoc));
    cap_front_end u_cap_front_end (.clock_i(clock_i), .rst_i(rst_i),
        .lat_i(lat), .meas_start_i(mstart), .meas_done_o(mdone));
    always #25 clock_i = ~clock_i;
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clock_i) begin
        cycles++;
        if (mstart === 1'b1) begin
            if (starts < 3) firsts[starts] = cmd;
            starts++;
            discards += int'(cmd.discard === 1'b1);
        end
        if (eoc === 1'b1) eocs++;
        if (cycles == 20000) begin
            fails++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        apb_q.psel <= 1'b1;
        apb_q.pwrite <= w;
        apb_q.paddr <= {24'h00_0000, a};
        apb_q.pwdata <= d;
        @(posedge clock_i);
        apb_q.penable <= 1'b1;
        do begin
            @(posedge clock_i);
        end while (pready !== 1'b1);
        rd_v = prdata;
        err_v = pslverr;
        apb_q.psel <= 1'b0;
        apb_q.penable <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic run(input int limit);
        int n;
        n = 0;
        starts = 0;
        discards = 0;
        eocs = 0;
        apb(1'b1, OFS_COMMAND, 32'h0000_0001);
        while (eocs < limit && n < 4000) begin
            @(posedge clock_i);
            n++;
        end
        repeat (4) @(posedge clock_i);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rd_v, {8'h00, CTRL_RST});
        apb(1'b0, 8'h1c, 32'h0);
        chk(32'(err_v), 32'h1);
    endtask
    task automatic t_single;
        apb(1'b1, OFS_CTRL, 32'h0001_0802);
        apb(1'b1, OFS_BANK0, 32'h0001_0002);
        lat <= 4'h9;
        run(1);
        chk(32'(starts), 32'd9);
        chk(32'(discards), 32'd3);
        chk(32'(firsts[0].kind), 32'(KIND_REF));
        chk(32'(firsts[1].port), 32'h1);
        chk(32'(firsts[2].kind), 32'(KIND_COMP_INT));
        chk(32'(eocs), 32'd1);
        lat <= 4'h0;
    endtask
    task automatic t_bank;
        apb(1'b1, OFS_CTRL, 32'h0080_0002);
        apb(1'b1, OFS_BANK1, 32'h0001_0000);
        run(1);
        chk(32'(starts), 32'd2);
        chk(32'(discards), 32'd0);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(32'(rd_v[F_ST_BANK]), 32'h1);
    endtask
    task automatic t_off;
        apb(1'b1, OFS_CTRL, 32'h0000_0002);
        apb(1'b1, OFS_BANK0, 32'h0000_0000);
        starts = 0;
        apb(1'b1, OFS_COMMAND, 32'h0000_0001);
        repeat (30) @(posedge clock_i);
        chk(32'(busy), 32'h0);
        chk(32'(starts), 32'd0);
    endtask
    task automatic t_diff;
        apb(1'b1, OFS_CTRL, 32'h0000_f70c);
        apb(1'b1, OFS_BANK0, 32'h0001_0000);
        run(1);
        chk(32'(starts), 32'd5);
        chk(32'(firsts[0].port), 32'h0);
        chk(32'(firsts[0].floating), 32'h1);
        chk(32'(firsts[0].inactive_dummy), 32'h1);
        chk(32'(firsts[1].port), 32'h2);
        chk(32'(firsts[2].kind), 32'(KIND_COMP_EXT));
    endtask
    task automatic t_pin;
        apb(1'b1, OFS_CTRL, 32'h0020_0002);
        apb(1'b1, OFS_BANK0, 32'h0003_0000);
        eocs = 0;
        gpio <= 4'h2;
        repeat (50) @(posedge clock_i);
        chk(32'(eocs), 32'd0);
        gpio <= 4'h4;
        repeat (50) @(posedge clock_i);
        chk(32'(eocs), 32'd1);
        gpio <= 4'h0;
    endtask
    task automatic t_dsp;
        apb(1'b1, OFS_CTRL, 32'h0040_0002);
        apb(1'b1, OFS_BANK0, 32'h0001_0000);
        eocs = 0;
        dstart <= 1'b1;
        @(posedge clock_i);
        dstart <= 1'b0;
        repeat (50) @(posedge clock_i);
        chk(32'(eocs), 32'd1);
        pend <= 1'b1;
        @(posedge clock_i);
        pend <= 1'b0;
        repeat (50) @(posedge clock_i);
        chk(32'(eocs), 32'd2);
    endtask
    task automatic t_timer;
        apb(1'b1, OFS_CTRL, 32'h0000_0002);
        apb(1'b1, OFS_INTERVAL0, 32'h0000_0003);
        apb(1'b1, OFS_BANK0, 32'h0002_0000);
        eocs = 0;
        repeat (12) begin
            lf <= 1'b1;
            repeat (3) @(posedge clock_i);
            lf <= 1'b0;
            repeat (3) @(posedge clock_i);
        end
        repeat (50) @(posedge clock_i);
        chk(32'(eocs), 32'd2);
    endtask
    task automatic t_cont;
        apb(1'b1, OFS_BANK0, 32'h0001_0000);
        apb(1'b1, OFS_INTERVAL0, 32'h0000_0005);
        run(3);
        chk(32'(eocs >= 3), 32'h1);
        apb(1'b1, OFS_BANK0, 32'h0000_0000);
        repeat (40) @(posedge clock_i);
        chk(32'(busy), 32'h0);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        t_regs();
        t_single();
        t_bank();
        t_off();
        t_diff();
        t_pin();
        t_dsp();
        t_cont();
        t_timer();
        wrap_up();
    end
endmodule
